// *** logic/ofmt_top.v ***
// octal serial output formatter: frame sequencer, bit and frame clocks,
// eight channel lanes and an AHB-Lite register slave
// assumes samples_i is synchronous to clock_i and stable around the
// sample clock rising edge; sample_clock_in_i is an asynchronous pin
`default_nettype none
`include "ofmt_map.vh"

module ofmt_top
(
   input  wire                           clock_i,                     // 250 MHz
   input  wire                           resetn_i,                    // async, low
   // ahb-lite slave
   input  wire                           hsel_i,                      // slave select
   input  wire [31:0]                    haddr_i,                     // byte address
   input  wire [1:0]                     htrans_i,                    // transfer type
   input  wire                           hwrite_i,                    // write strobe
   input  wire [2:0]                     hsize_i,                     // transfer size
   input  wire [31:0]                    hwdata_i,                    // write data
   input  wire                           hready_i,                    // bus ready
   output reg  [31:0]                    hrdata_o,                    // read data
   output reg                            hreadyout_o,                 // never waits
   output reg                            hresp_o,                     // always okay
   // converter side
   input  wire                           sample_clock_in_i,           // pin clock
   input  wire [`OFMT_CHANNELS*`OFMT_SAMPLE_W-1:0] samples_i,         // 8 codes
   // serial link
   output wire [`OFMT_CHANNELS-1:0]      data_out_o,                  // lane bits
   output reg                            bit_clock_out_o,             // bit clock
   output reg                            frame_clock_out_pos_o,       // frame clock
   // analog configuration levels
   output reg                            differential_clock_select_o, // clock mode
   output reg                            duty_correction_enable_o,    // dcc on
   output reg                            cm_raise_enable_o            // vcm boost
);

   // sequencer states, one-hot
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   // registers
   reg [`OFMT_CTRL_W-1:0]     ctrl_q;     // control bits
   reg [`OFMT_BITLEN_W-1:0]   bitlen_q;   // cycles per bit
   reg                        ovr_q;      // sticky frame overrun
   reg [`OFMT_STAT_CNT_W-1:0] fcnt_q;     // frames started
   // ahb data phase bookkeeping
   reg                        wr_pend_q;  // write data phase next
   reg [7:0]                  wr_addr_q;  // write offset
   // sequencer
   reg [1:0]                  state_q;    // one-hot state
   reg [3:0]                  bit_q;      // bit index in word
   reg [`OFMT_BITLEN_W-1:0]   phase_q;    // cycle inside bit
   reg                        clk_d1_q;   // delayed synced clock
   reg                        sdr_q;      // rate latched per word
   // combinational
   wire                       clk_s;      // synced sample clock
   wire                       frame_edge; // sample clock rising
   wire [`OFMT_BITLEN_W-1:0]  len;        // bit length, clamped
   wire [`OFMT_BITLEN_W-1:0]  mid;        // phase whose flop edge lands mid-bit
   wire                       bit_end;    // last cycle of a bit
   wire                       run;        // in a word
   wire                       load;       // lanes take new samples
   wire                       shift;      // lanes step a bit
   wire                       addr_ok;    // valid address phase
   wire                       wr_ctrl;    // control write now
   wire                       wr_len;     // bitlen write now
   wire                       wr_stat;    // status write now

   // sample clock crosses in two flops before anything reads it
   ofmt_sync #(.W(1)) u_clk_sync
   (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .async_i  (sample_clock_in_i),
      .sync_o   (clk_s)
   );

   // edge finder on the synced level only
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         clk_d1_q <= 1'b0;
      end
      else
      begin
         clk_d1_q <= clk_s;
      end
   end

   assign frame_edge = clk_s & ~clk_d1_q;
   // a bit shorter than two cycles has no middle for the bit clock
   assign len     = (bitlen_q < `OFMT_BITLEN_MIN) ? `OFMT_BITLEN_MIN : bitlen_q;
   // bit clock flops are set one phase early so the edge sits mid-bit, not on a data change
   assign mid     = {1'b0, len[`OFMT_BITLEN_W-1:1]} - 8'h01;
   assign run     = state_q[1];
   assign bit_end = run & (phase_q == len - 8'h01);
   // a new edge always restarts the word so lanes stay on the frame
   assign load    = frame_edge;
   assign shift   = bit_end & (bit_q != `OFMT_LAST_BIT) & ~frame_edge;

   // eight lanes share one load and shift strobe
   genvar g;
   generate
      for (g = 0; g < `OFMT_CHANNELS; g = g + 1)
      begin : g_lane
         ofmt_lane u_lane
         (
            .clock_i     (clock_i),
            .resetn_i    (resetn_i),
            .load_i      (load),
            .shift_i     (shift),
            .sample_i    (samples_i[g*`OFMT_SAMPLE_W +: `OFMT_SAMPLE_W]),
            .twos_i      (ctrl_q[`OFMT_CTRL_TWOS_BIT]),
            .msb_first_i (ctrl_q[`OFMT_CTRL_MSBF_BIT]),
            .ser_o       (data_out_o[g])
         );
      end
   endgenerate

   // frame sequencer: counts cycles per bit and bits per word
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_q <= ST_IDLE;
         bit_q   <= 4'h0;
         phase_q <= {`OFMT_BITLEN_W{1'b0}};
         sdr_q   <= 1'b0;
      end
      else if (frame_edge)
      begin
         // mode bits take effect at a word boundary only
         state_q <= ST_RUN;
         bit_q   <= 4'h0;
         phase_q <= {`OFMT_BITLEN_W{1'b0}};
         sdr_q   <= ctrl_q[`OFMT_CTRL_SDR_BIT];
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               phase_q <= {`OFMT_BITLEN_W{1'b0}};
            end
            ST_RUN:
            begin
               if (bit_end)
               begin
                  phase_q <= {`OFMT_BITLEN_W{1'b0}};
                  if (bit_q == `OFMT_LAST_BIT)
                  begin
                     state_q <= ST_IDLE;
                  end
                  else
                  begin
                     bit_q <= bit_q + 4'h1;
                  end
               end
               else
               begin
                  phase_q <= phase_q + 8'h01;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // bit and frame clocks are driven by the same sequencer as the data; the bit clock rises mid-bit
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bit_clock_out_o       <= 1'b0;
         frame_clock_out_pos_o <= 1'b0;
      end
      else if (frame_edge)
      begin
         // frame rises with the first bit of every lane
         frame_clock_out_pos_o <= 1'b1;
         bit_clock_out_o       <= 1'b0;
      end
      else if (run)
      begin
         // frame falls halfway through the word: one cycle per word
         if (shift && (bit_q + 4'h1 == `OFMT_FRAME_HALF))
         begin
            frame_clock_out_pos_o <= 1'b0;
         end
         else if (bit_end && (bit_q == `OFMT_LAST_BIT))
         begin
            frame_clock_out_pos_o <= 1'b0;
         end
         if (sdr_q)
         begin
            // one rising edge in the middle of every bit
            if (phase_q == mid)
            begin
               bit_clock_out_o <= 1'b1;
            end
            else if (bit_end)
            begin
               bit_clock_out_o <= 1'b0;
            end
         end
         else if (phase_q == mid)
         begin
            // rise mid even bits, fall mid odd bits: half the rate
            bit_clock_out_o <= ~bit_q[0];
         end
      end
   end

   // ahb-lite decode; only word transfers are meaningful here
   assign addr_ok = hsel_i & hready_i & htrans_i[1];
   assign wr_ctrl = wr_pend_q & (wr_addr_q == `OFMT_CTRL_OFS);
   assign wr_len  = wr_pend_q & (wr_addr_q == `OFMT_BITLEN_OFS);
   assign wr_stat = wr_pend_q & (wr_addr_q == `OFMT_STATUS_OFS);

   // address phase capture and zero-wait read data
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
         hrdata_o    <= 32'h00000000;
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
      end
      else
      begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         wr_pend_q   <= addr_ok & hwrite_i;
         wr_addr_q   <= haddr_i[7:0];
         hrdata_o    <= 32'h00000000;
         if (addr_ok && !hwrite_i)
         begin
            case (haddr_i[7:0])
               `OFMT_CTRL_OFS:
               begin
                  hrdata_o <= {26'h0000000, ctrl_q};
               end
               `OFMT_BITLEN_OFS:
               begin
                  hrdata_o <= {24'h000000, bitlen_q};
               end
               `OFMT_STATUS_OFS:
               begin
                  hrdata_o <= {16'h0000, fcnt_q, 6'h00, ovr_q, run};
               end
               default:
               begin
                  // unmapped offsets read zero with an okay answer
                  hrdata_o <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // software registers; configuration levels leave straight from flops
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q                      <= `OFMT_CTRL_RST;
         bitlen_q                    <= `OFMT_BITLEN_RST;
         differential_clock_select_o <= 1'b0;
         duty_correction_enable_o    <= 1'b0;
         cm_raise_enable_o           <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q <= hwdata_i[`OFMT_CTRL_W-1:0];
         end
         if (wr_len)
         begin
            bitlen_q <= hwdata_i[`OFMT_BITLEN_W-1:0];
         end
         differential_clock_select_o <= ctrl_q[`OFMT_CTRL_DIFF_BIT];
         duty_correction_enable_o    <= ctrl_q[`OFMT_CTRL_DCC_BIT];
         cm_raise_enable_o           <= ctrl_q[`OFMT_CTRL_CMUP_BIT];
      end
   end

   // status: frame counter and sticky overrun; a new overrun beats a clear
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ovr_q  <= 1'b0;
         fcnt_q <= {`OFMT_STAT_CNT_W{1'b0}};
      end
      else
      begin
         if (frame_edge)
         begin
            fcnt_q <= fcnt_q + 8'h01;
         end
         if (frame_edge && run && !(bit_end && bit_q == `OFMT_LAST_BIT))
         begin
            ovr_q <= 1'b1;
         end
         else if (wr_stat && hwdata_i[`OFMT_STAT_OVR_BIT])
         begin
            ovr_q <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** logic/ofmt_map.vh ***
// register offsets, field positions, reset values and timing counts
// for the octal serial output formatter; included by the design files
`ifndef OFMT_MAP_VH
`define OFMT_MAP_VH

// register byte offsets on the AHB-Lite slave
`define OFMT_CTRL_OFS        8'h00
`define OFMT_BITLEN_OFS      8'h04
`define OFMT_STATUS_OFS      8'h08

// control register fields
`define OFMT_CTRL_TWOS_BIT   0
`define OFMT_CTRL_MSBF_BIT   1
`define OFMT_CTRL_SDR_BIT    2
`define OFMT_CTRL_DIFF_BIT   3
`define OFMT_CTRL_DCC_BIT    4
`define OFMT_CTRL_CMUP_BIT   5
`define OFMT_CTRL_W          6
`define OFMT_CTRL_RST        6'h00

// bit length register: clock_i cycles per serial bit
`define OFMT_BITLEN_W        8
`define OFMT_BITLEN_RST      8'h02
`define OFMT_BITLEN_MIN      8'h02

// status register fields
`define OFMT_STAT_BUSY_BIT   0
`define OFMT_STAT_OVR_BIT    1
`define OFMT_STAT_CNT_LSB    8
`define OFMT_STAT_CNT_W      8

// word geometry
`define OFMT_CHANNELS        8
`define OFMT_SAMPLE_W        10
`define OFMT_WORD_W          12
`define OFMT_LAST_BIT        4'hB
`define OFMT_FRAME_HALF      4'h6

`endif

// *** logic/ofmt_sync.v ***
// two flip-flop synchroniser for levels entering the clock_i domain
// assumes the input is a level slow enough to be sampled by clock_i
`default_nettype none

module ofmt_sync
#(
   parameter W = 1
)
(
   input  wire         clock_i,   // block clock
   input  wire         resetn_i,  // async reset, active low
   input  wire [W-1:0] async_i,   // level from another domain
   output reg  [W-1:0] sync_o     // level safe for clock_i logic
);

   // first stage, read only by the second stage
   reg [W-1:0] meta_q;

   // two stages; the first may go metastable and is never decoded
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_q <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

`default_nettype wire

// *** logic/ofmt_lane.v ***
// one channel lane: codes, pads and shifts a 12-bit word serially
// assumes load and shift strobes from the frame sequencer, never together
`default_nettype none
`include "ofmt_map.vh"

module ofmt_lane
(
   input  wire                      clock_i,     // block clock
   input  wire                      resetn_i,    // async reset, active low
   input  wire                      load_i,      // start of a word
   input  wire                      shift_i,     // advance to next bit
   input  wire [`OFMT_SAMPLE_W-1:0] sample_i,    // converter code
   input  wire                      twos_i,      // two's complement coding
   input  wire                      msb_first_i, // high bit leads
   output reg                       ser_o        // serial data bit
);

   // remaining bits, bit 0 goes out next
   reg [`OFMT_WORD_W-1:0]   rest_q;
   // coded sample and first-out ordered word
   reg [`OFMT_SAMPLE_W-1:0] code;
   reg [`OFMT_WORD_W-1:0]   seq;
   integer                  i;

   // coding and ordering of the word, index 0 leaves first
   always @*
   begin
      code = sample_i;
      if (twos_i)
      begin
         code[`OFMT_SAMPLE_W-1] = ~sample_i[`OFMT_SAMPLE_W-1];
      end
      // default: two pad zeros first, then low bit upward
      seq = {code, 2'b00};
      if (msb_first_i)
      begin
         // reversed: high bit first, pad zeros last
         seq = {`OFMT_WORD_W{1'b0}};
         for (i = 0; i < `OFMT_SAMPLE_W; i = i + 1)
         begin
            seq[i] = code[`OFMT_SAMPLE_W-1-i];
         end
      end
   end

   // shift register; the output bit is always a flop
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rest_q <= {`OFMT_WORD_W{1'b0}};
         ser_o  <= 1'b0;
      end
      else if (load_i)
      begin
         ser_o  <= seq[0];
         rest_q <= {1'b0, seq[`OFMT_WORD_W-1:1]};
      end
      else if (shift_i)
      begin
         ser_o  <= rest_q[0];
         rest_q <= {1'b0, rest_q[`OFMT_WORD_W-1:1]};
      end
   end

endmodule

`default_nettype wire

// *** test/ofmt_top_properties.sv ***
// assertions on the formatter's register slave and link framing
// bound into every ofmt_top; sees that module's ports only
`default_nettype none
module ofmt_top_check
(
   input wire logic        clock_i,
   input wire logic        resetn_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        bit_clock_out_o,
   input wire logic        frame_clock_out_pos_o,
   input wire logic        differential_clock_select_o,
   input wire logic        duty_correction_enable_o,
   input wire logic        cm_raise_enable_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   logic       rd_q, wr_q, fr_q, bc_q; // data phase kinds, edge history
   logic [7:0] ad_q, bl_q;             // phase address, bit length shadow
   logic [5:0] ct_q;                   // control shadow
   logic [9:0] cnt_q;                  // cycles since frame rose
   logic [3:0] rc_q;                   // bit clock rises in this frame
   wire        take = hsel_i && hready_i && htrans_i[1];
   wire  [7:0] len = (bl_q < 8'h02) ? 8'h02 : bl_q;
   wire        frs = frame_clock_out_pos_o && !fr_q;

   // shadows of written registers and frame phase counters
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         {rd_q, wr_q, fr_q, bc_q, ad_q, ct_q, cnt_q, rc_q} <= '0;
         bl_q <= 8'h02;
      end
      else
      begin
         rd_q <= take && !hwrite_i;
         wr_q <= take && hwrite_i;
         ad_q <= haddr_i[7:0];
         fr_q <= frame_clock_out_pos_o;
         bc_q <= bit_clock_out_o;
         if (wr_q && ad_q == 8'h00)
            ct_q <= hwdata_i[5:0];
         if (wr_q && ad_q == 8'h04)
            bl_q <= hwdata_i[7:0];
         // saturates so a long idle link never wraps into a false phase
         cnt_q <= frs ? 10'h001 : cnt_q + {9'h000, cnt_q != 10'h3FF};
         rc_q <= frs ? 4'h0 : rc_q + {3'h0, bit_clock_out_o && !bc_q};
      end
   end

   ready_after_reset_a: assert property ($past(resetn_i) |-> hreadyout_o)
      else $error("slave not ready");
   okay_response_a: assert property (take |=> !hresp_o [*2])
      else $error("response not okay");
   read_idle_zero_a: assert property (!rd_q |-> hrdata_o == 32'h0)
      else $error("read data outside read phase");
   ctrl_readback_a: assert property (
      rd_q && ad_q == 8'h00 |-> hrdata_o == {26'h0, ct_q})
      else $error("control read wrong");
   bitlen_readback_a: assert property (
      rd_q && ad_q == 8'h04 |-> hrdata_o == {24'h0, bl_q})
      else $error("bit length read wrong");
   config_follow_a: assert property (
      {cm_raise_enable_o, duty_correction_enable_o, differential_clock_select_o}
      == $past(ct_q[5:3]))
      else $error("config levels stale");
   frame_start_low_a: assert property (frs |-> !bit_clock_out_o)
      else $error("bit clock high at frame start");
   frame_high_len_a: assert property (
      $fell(frame_clock_out_pos_o) |-> cnt_q == 10'(6 * len))
      else $error("frame high length wrong");
   bit_rise_mid_a: assert property (
      $rose(bit_clock_out_o) |-> cnt_q % len == len / 2)
      else $error("bit clock rise off centre");
   ddr_fall_mid_a: assert property (
      $fell(bit_clock_out_o) && !ct_q[2] && !frs |-> cnt_q % len == len / 2)
      else $error("bit clock fall off centre");
   rise_count_a: assert property (
      $fell(frame_clock_out_pos_o) |-> rc_q == (ct_q[2] ? 4'h6 : 4'h3))
      else $error("bit clock rate wrong");
endmodule

bind ofmt_top ofmt_top_check chk_i
(
   .clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
   .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .bit_clock_out_o,
   .frame_clock_out_pos_o, .differential_clock_select_o,
   .duty_correction_enable_o, .cm_raise_enable_o
);
`default_nettype wire

// *** test/ofmt_rx_model.sv ***
// receiver model: frames words off the link by frame and bit clock
// assumes every link output changes only on clock_i edges
`default_nettype none
module ofmt_rx_model
(
   input  wire logic        clock_i,  // block clock, samples the link
   input  wire logic        resetn_i, // async reset, active low
   input  wire logic        sdr_i,    // capture on rising bit clock only
   input  wire logic [7:0]  data_i,   // lane bits
   input  wire logic        bclk_i,   // bit clock
   input  wire logic        frame_i,  // frame clock
   output var  logic [95:0] word_o,   // lane g at [12g+11:12g], first bit low
   output var  logic        valid_o   // one cycle after the twelfth bit
);
   logic [3:0] idx_q; // next bit slot, 12 when idle
   logic       bc_q;  // bit clock last cycle
   logic       fr_q;  // frame clock last cycle

   // a frame rise restarts the word, so a cut-off word is dropped
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         idx_q <= 4'hC;
         {bc_q, fr_q, valid_o} <= '0;
         word_o <= '0;
      end
      else
      begin
         bc_q <= bclk_i;
         fr_q <= frame_i;
         valid_o <= 1'b0;
         if (frame_i && !fr_q)
            idx_q <= 4'h0;
         else if (bclk_i != bc_q && (bclk_i || !sdr_i) && idx_q < 4'hC)
         begin
            for (int g = 0; g < 8; g++)
               word_o[12 * g + idx_q] <= data_i[g];
            idx_q <= idx_q + 4'h1;
            valid_o <= (idx_q == 4'hB);
         end
      end
   end
endmodule
`default_nettype wire

// *** test/octal_adc_serial_output_formatter_test.sv ***
// self-checking bench for ofmt_top: register bus, coding and framing
// a receiver model captures words; a watcher compares them in order
`default_nettype none
module octal_adc_serial_output_formatter_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock_i, resetn_i, hsel, hwr, sclk, sdr;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [79:0] smp;
   logic [95:0] expq[$]; // expected words, oldest first
   wire  [31:0] hrdata;
   wire  [7:0]  dout;
   wire  [95:0] word;
   wire         hrdy, hresp, bclk, fclk, dsel, dcc, cmu, vld;
   int          mismatches, checks;

   ofmt_top dut
   (
      .clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .sample_clock_in_i(sclk), .samples_i(smp), .data_out_o(dout),
      .bit_clock_out_o(bclk), .frame_clock_out_pos_o(fclk),
      .differential_clock_select_o(dsel), .duty_correction_enable_o(dcc),
      .cm_raise_enable_o(cmu)
   );

   ofmt_rx_model rx
   (
      .clock_i(clock_i), .resetn_i(resetn_i), .sdr_i(sdr), .data_i(dout),
      .bclk_i(bclk), .frame_i(fclk), .word_o(word), .valid_o(vld)
   );

   initial
   begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask

   // one single transfer; waits on ready, data taken at the closing edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clock_i);
      {hsel, htrans, hwr, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
      do @(posedge clock_i); while (hrdy !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge clock_i); while (hrdy !== 1'b1);
      r = hrdata;
   endtask

   // expected lanes in wire order, first bit at the low index
   function automatic logic [95:0] exp_word(input logic [79:0] s, input logic [5:0] ct);
      logic [9:0]  c;
      logic [11:0] w;
      for (int g = 0; g < 8; g++)
      begin
         c = s[10 * g +: 10];
         c[9] = c[9] ^ ct[0];
         w = {c, 2'b00};
         for (int k = 0; k < 12; k++)
            exp_word[12 * g + k] = ct[1] ? w[11 - k] : w[k];
      end
   endfunction

   function automatic logic [79:0] rnd();
      rnd = {16'($urandom()), $urandom(), $urandom()};
   endfunction

   // one sample clock period, then the sample clock stands still while the link sends the word
   task automatic frame(input logic [79:0] s, input logic [5:0] ct, input int len);
      @(posedge clock_i);
      smp <= s;
      expq.push_back(exp_word(s, ct));
      #1.3 sclk = 1'b1;
      #40 sclk = 1'b0;
      #40;
      repeat (12 * len + 12) @(posedge clock_i);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // compares each captured word with the oldest expectation
   always @(posedge clock_i)
   begin
      if (vld === 1'b1)
      begin
         if (expq.size() == 0)
            chk(word, ~word, "unexpected word");
         else
            chk(word, expq.pop_front(), "word");
      end
   end

   // cuts a hang short
   initial
   begin
      repeat (12000) @(posedge clock_i);
      mismatches++;
      $display("FAIL %0t timeout", $time);
      finish_test();
   end

   initial
   begin
      {resetn_i, hsel, hwr, sclk, sdr, haddr, hwdata, htrans, smp} = '0;
      mismatches = 0;
      checks = 0;
      void'($urandom(32'hD2680A44));
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      // reset values, unmapped hole, default coding at the shortest bit
      bus(1'b0, 8'h00, 32'h0, rd);
      chk(96'(rd), 96'h0, "ctrl reset");
      bus(1'b0, 8'h04, 32'h0, rd);
      chk(96'(rd), 96'h2, "bitlen reset");
      bus(1'b0, 8'h0C, 32'h0, rd);
      chk(96'(rd), 96'h0, "hole read");
      chk(96'({cmu, dcc, dsel}), 96'h0, "config reset");
      frame(rnd(), 6'h00, 2);
      frame(80'h0, 6'h00, 2);
      frame({8{10'h3FF}}, 6'h00, 2);
      // analog configuration levels follow the control register
      bus(1'b1, 8'h00, 32'h38, rd);
      repeat (2) @(posedge clock_i);
      chk(96'({cmu, dcc, dsel}), 96'h7, "config set");
      bus(1'b0, 8'h00, 32'h0, rd);
      chk(96'(rd), 96'h38, "ctrl readback");
      // every coding, order and rate combination, bit length 3 with two's complement coding, else 4
      for (int m = 0; m < 8; m++)
      begin
         bus(1'b1, 8'h04, m[0] ? 32'h3 : 32'h4, rd);
         bus(1'b1, 8'h00, 32'(m), rd);
         sdr <= m[2];
         frame(rnd(), 6'(m), m[0] ? 3 : 4);
         frame(m[0] ? {8{10'h3FF}} : 80'h0, 6'(m), m[0] ? 3 : 4);
      end
      // a second sample edge mid word restarts it with the fresh sample
      bus(1'b1, 8'h00, 32'h0, rd);
      bus(1'b1, 8'h04, 32'h2, rd);
      sdr <= 1'b0;
      @(posedge clock_i);
      smp <= rnd();
      #1.3 sclk = 1'b1;
      #40 sclk = 1'b0;
      @(posedge clock_i);
      smp <= rnd();
      #1 expq.push_back(exp_word(smp, 6'h00));
      #36.3 sclk = 1'b1;
      #40 sclk = 1'b0;
      repeat (40) @(posedge clock_i);
      bus(1'b0, 8'h08, 32'h0, rd);
      chk(96'(rd[15:0]), 96'h1502, "status after restart");
      bus(1'b1, 8'h08, 32'h2, rd);
      bus(1'b0, 8'h08, 32'h0, rd);
      chk(96'(rd[1]), 96'h0, "overrun clear");
      chk(96'(expq.size()), 96'h0, "words missing");
      finish_test();
   end
endmodule
`default_nettype wire
